// ==== include/fhr_consts.svh ====
// Purpose: Offsets, field positions, widths and reset values of the host register slice.
// Assumes: 5-bit address, 8-bit data processor bus.
// Notes: Definitions only.
`ifndef FHR_CONSTS_SVH
`define FHR_CONSTS_SVH
`define FHR_ADDR_W 5
`define FHR_DATA_W 8
`define FHR_RD_DEC_OUT 5'h00
`define FHR_WR_DEC_CTRL1 5'h02
`define FHR_WR_PERIOD_LOW 5'h0a
`define FHR_WR_PERIOD_MID 5'h0b
`define FHR_WR_PERIOD_HIGH 5'h0c
`define FHR_WR_UNUSED_0D 5'h0d
`define FHR_WR_DEC_IN_CLK 5'h0e
`define FHR_WR_DEC_OUT_CLK 5'h0f
`define FHR_WR_UNUSED_10 5'h10
`define FHR_WR_ENC_IN_CLK 5'h11
`define FHR_WR_ENC_OUT_CLK 5'h12
`define FHR_WR_UNUSED_13 5'h13
`define FHR_WR_UNUSED_14 5'h14
`define FHR_WR_RSVD_A 5'h15
`define FHR_WR_RSVD_B 5'h16
`define FHR_WR_NORM_TEST 5'h17
`define FHR_WR_ERR_TEST 5'h18
`define FHR_BIT_RATE_THIRD 4
`define FHR_BIT_DATA 0
`define FHR_BIT_ERR0 1
`define FHR_BIT_ERR1 2
`define FHR_BIT_ERR2_ERASE1 3
`define FHR_BIT_ERASE_COMB 5
`define FHR_PERIOD_W 24
`define FHR_ERASE_DELAY 4
`define FHR_RESET_BYTE 8'h00
`define FHR_RESET_PERIOD 24'h000000
`endif

// ==== include/fhr_pkg.sv ====
// Purpose: Types shared by the host register slice.
// Assumes: Constants come from fhr_consts.svh.
// Notes: Types only.
package fhr_pkg;
  typedef enum logic [3:0] {
    FHR_CLK_DEC_IN = 4'h1,
    FHR_CLK_DEC_OUT = 4'h2,
    FHR_CLK_ENC_IN = 4'h4,
    FHR_CLK_ENC_OUT = 4'h8
  } fhr_clk_sel_type;
endpackage

// ==== hw/fhr_host_regs.sv ====
// Purpose: Processor register slice: error-rate period, clock strobes, test enables, decoder output read.
// Assumes: Bus pins synchronous to clk; core supplies error flags and erasures per decoded bit.
// Notes: Erasure delay line length is a fixed constant matching the core latency.
// Contract
// - Addresses 0Dh,10h,13h,14h have no function
// - Read bit 1 flags first stream errors
// - Read bit 2 flags second stream errors
// - Rate third: bit 3 flags third stream
// - Otherwise bit 3 gives delayed second erasure
// - Rate third: bit 5 ORs delayed erasures
// - Otherwise bit 5 gives delayed first erasure
// - Control bit 4 selects rate third
`timescale 1ns/10ps
`include "fhr_consts.svh"
module fhr_host_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Processor bus
  input wire logic [`FHR_ADDR_W-1:0] bus_addr,
  input wire logic [`FHR_DATA_W-1:0] bus_wdata,
  input wire logic bus_cs_n,
  input wire logic bus_wr_n,
  input wire logic bus_rd_n,
  output logic [`FHR_DATA_W-1:0] bus_rdata,
  // Decoder core side
  input wire logic decoded_bit_out,
  input wire logic bit_strobe,
  input wire logic first_stream_error_flag,
  input wire logic second_stream_error_flag,
  input wire logic third_stream_error_flag,
  input wire logic first_stream_erasure_in,
  input wire logic second_stream_erasure_in,
  input wire logic third_stream_erasure_in,
  input wire logic erasure_strobe,
  // Configuration out
  output logic [`FHR_PERIOD_W-1:0] error_rate_period,
  output logic [`FHR_DATA_W-1:0] normalization_test_enable,
  output logic [`FHR_DATA_W-1:0] error_rate_test_enable,
  output logic rate_third,
  output logic [3:0] host_clock_pulse
);
  logic wr_en;
  logic [`FHR_PERIOD_W-1:0] period_reg, period_next;
  logic [`FHR_DATA_W-1:0] ntest_reg, ntest_next, etest_reg, etest_next;
  logic rate_reg, rate_next;
  logic [3:0] pulse_reg, pulse_next;
  logic [`FHR_DATA_W-1:0] rdata_reg, rdata_next;
  logic [2:0] erase_in, erase_d;
  logic erase0_d, erase1_d, erase2_d;

  assign wr_en = !bus_cs_n && !bus_wr_n;
  assign erase_in = {third_stream_erasure_in, second_stream_erasure_in, first_stream_erasure_in};
  assign erase0_d = erase_d[0];
  assign erase1_d = erase_d[1];
  assign erase2_d = erase_d[2];

  always_comb begin
    period_next = period_reg;
    ntest_next = ntest_reg;
    etest_next = etest_reg;
    rate_next = rate_reg;
    pulse_next = 4'h0;
    if (wr_en) begin
      case (bus_addr)
        `FHR_WR_DEC_CTRL1: rate_next = bus_wdata[`FHR_BIT_RATE_THIRD];
        `FHR_WR_PERIOD_LOW: period_next[7:0] = bus_wdata;
        `FHR_WR_PERIOD_MID: period_next[15:8] = bus_wdata;
        `FHR_WR_PERIOD_HIGH: period_next[23:16] = bus_wdata;
        `FHR_WR_DEC_IN_CLK: pulse_next = fhr_pkg::FHR_CLK_DEC_IN;
        `FHR_WR_DEC_OUT_CLK: pulse_next = fhr_pkg::FHR_CLK_DEC_OUT;
        `FHR_WR_ENC_IN_CLK: pulse_next = fhr_pkg::FHR_CLK_ENC_IN;
        `FHR_WR_ENC_OUT_CLK: pulse_next = fhr_pkg::FHR_CLK_ENC_OUT;
        `FHR_WR_NORM_TEST: ntest_next = bus_wdata;
        `FHR_WR_ERR_TEST: etest_next = bus_wdata;
        // Unused and reserved addresses take the write with no effect
        default: begin
          period_next = period_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      period_reg <= `FHR_RESET_PERIOD;
      ntest_reg <= `FHR_RESET_BYTE;
      etest_reg <= `FHR_RESET_BYTE;
      rate_reg <= 1'b0;
      pulse_reg <= 4'h0;
    end else begin
      period_reg <= period_next;
      ntest_reg <= ntest_next;
      etest_reg <= etest_next;
      rate_reg <= rate_next;
      pulse_reg <= pulse_next;
    end
  end

  // Erasures ride a shift line advanced on each erasure strobe so they meet the matching error flags
  generate
    for (genvar s = 0; s < 3; s++) begin : g_erase
      logic [`FHR_ERASE_DELAY-1:0] dly_reg, dly_next;
      always_comb begin
        dly_next = dly_reg;
        if (erasure_strobe) begin
          dly_next = {dly_reg[`FHR_ERASE_DELAY-2:0], erase_in[s]};
        end
      end
      always_ff @(posedge clk) begin
        if (!resetn) begin
          dly_reg <= '0;
        end else begin
          dly_reg <= dly_next;
        end
      end
      assign erase_d[s] = dly_reg[`FHR_ERASE_DELAY-1];
    end
  endgenerate

  // Read data is held between strobes so the host sees a stable byte
  always_comb begin
    rdata_next = rdata_reg;
    if (bit_strobe) begin
      rdata_next = 8'h00;
      rdata_next[`FHR_BIT_DATA] = decoded_bit_out;
      rdata_next[`FHR_BIT_ERR0] = first_stream_error_flag;
      rdata_next[`FHR_BIT_ERR1] = second_stream_error_flag;
      rdata_next[`FHR_BIT_ERR2_ERASE1] = rate_reg ? third_stream_error_flag : erase1_d;
      rdata_next[`FHR_BIT_ERASE_COMB] = rate_reg ? (erase0_d | erase1_d | erase2_d) : erase0_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_reg <= `FHR_RESET_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Only one read register lives in this slice; other addresses read zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bus_rdata <= `FHR_RESET_BYTE;
    end else if (!bus_cs_n && !bus_rd_n && bus_addr == `FHR_RD_DEC_OUT) begin
      bus_rdata <= rdata_next;
    end else begin
      bus_rdata <= `FHR_RESET_BYTE;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      error_rate_period <= `FHR_RESET_PERIOD;
      normalization_test_enable <= `FHR_RESET_BYTE;
      error_rate_test_enable <= `FHR_RESET_BYTE;
      rate_third <= 1'b0;
      host_clock_pulse <= 4'h0;
    end else begin
      error_rate_period <= period_next;
      normalization_test_enable <= ntest_next;
      error_rate_test_enable <= etest_next;
      rate_third <= rate_next;
      host_clock_pulse <= pulse_next;
    end
  end

  chk_period_low_load: assert property (@(posedge clk) disable iff (!resetn)
    wr_en && bus_addr == `FHR_WR_PERIOD_LOW |=> error_rate_period[7:0] == $past(bus_wdata))
    else $error("period low byte not loaded");
  chk_period_high_load: assert property (@(posedge clk) disable iff (!resetn)
    wr_en && bus_addr == `FHR_WR_PERIOD_HIGH |=> error_rate_period[23:16] == $past(bus_wdata)
      && $stable(error_rate_period[15:0]))
    else $error("period high byte not loaded");
  chk_unused_no_effect: assert property (@(posedge clk) disable iff (!resetn)
    wr_en && (bus_addr == `FHR_WR_UNUSED_0D || bus_addr == `FHR_WR_RSVD_A)
      |=> $stable(error_rate_period) && host_clock_pulse == 4'h0)
    else $error("unused address changed state");
  chk_clock_single_pulse: assert property (@(posedge clk) disable iff (!resetn)
    wr_en && bus_addr == `FHR_WR_DEC_IN_CLK ##1 !wr_en |=> host_clock_pulse == 4'h0)
    else $error("clock event longer than one cycle");
  chk_clock_pulse_sel: assert property (@(posedge clk) disable iff (!resetn)
    wr_en && bus_addr == `FHR_WR_ENC_OUT_CLK |=> host_clock_pulse == 4'h8)
    else $error("encoder output clock event missing");
  chk_err0_flag: assert property (@(posedge clk) disable iff (!resetn)
    bit_strobe |=> rdata_reg[1] == $past(first_stream_error_flag) && rdata_reg[0] == $past(decoded_bit_out))
    else $error("first stream error flag wrong");
  chk_err1_flag: assert property (@(posedge clk) disable iff (!resetn)
    bit_strobe |=> rdata_reg[2] == $past(second_stream_error_flag))
    else $error("second stream error flag wrong");
  chk_bit3_mux: assert property (@(posedge clk) disable iff (!resetn)
    bit_strobe |=> rdata_reg[3] == ($past(rate_reg) ? $past(third_stream_error_flag) : $past(erase1_d)))
    else $error("bit 3 selection wrong");
  chk_bit5_mux: assert property (@(posedge clk) disable iff (!resetn)
    bit_strobe |=> rdata_reg[5] == ($past(rate_reg) ? $past(erase0_d | erase1_d | erase2_d) : $past(erase0_d)))
    else $error("bit 5 selection wrong");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!resetn)
    bus_rdata[4] == 1'b0 && bus_rdata[7:6] == 2'b00)
    else $error("reserved read bits set");
  chk_rate_select: assert property (@(posedge clk) disable iff (!resetn)
    wr_en && bus_addr == `FHR_WR_DEC_CTRL1 |=> rate_third == $past(bus_wdata[4]))
    else $error("rate third not taken");
  chk_period_mid_load: assert property (@(posedge clk) disable iff (!resetn)
    wr_en && bus_addr == `FHR_WR_PERIOD_MID |=> error_rate_period[15:8] == $past(bus_wdata))
    else $error("period middle byte not loaded");
  chk_read_path: assert property (@(posedge clk) disable iff (!resetn)
    !bus_cs_n && !bus_rd_n && bus_addr == `FHR_RD_DEC_OUT |=> bus_rdata == rdata_reg)
    else $error("read byte differs from held byte");
  chk_read_other_zero: assert property (@(posedge clk) disable iff (!resetn)
    !(!bus_cs_n && !bus_rd_n && bus_addr == `FHR_RD_DEC_OUT) |=> bus_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_pulse_idle: assert property (@(posedge clk) disable iff (!resetn)
    !wr_en |=> host_clock_pulse == 4'h0)
    else $error("clock event without a write");
endmodule // fhr_host_regs

// ==== verification/fhr_host_model.sv ====
// Purpose: Host processor model driving the register bus.
// Assumes: A request is taken at the first edge it is seen.
// Notes: Idle address and data are inverted so stale values never look valid.
`timescale 1ns/10ps
`include "fhr_consts.svh"
module fhr_host_model (
  // Bus
  input wire logic clk,
  input wire logic [`FHR_DATA_W-1:0] rdata,
  output logic [`FHR_ADDR_W-1:0] addr,
  output logic [`FHR_DATA_W-1:0] wdata,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n
);
  initial begin
    addr = 5'h1f;
    wdata = 8'h00;
    {cs_n, wr_n, rd_n} = 3'h7;
  end
  task automatic idle();
    {cs_n, wr_n, rd_n} <= 3'h7;
    addr <= ~addr;
    wdata <= ~wdata;
  endtask
  // Callers give fixed and reserved bits their prescribed values
  task automatic wr(input logic [`FHR_ADDR_W-1:0] a, input logic [`FHR_DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    {cs_n, wr_n} <= 2'h0;
    @(posedge clk);
    idle();
  endtask
  task automatic rd(input logic [`FHR_ADDR_W-1:0] a, output logic [`FHR_DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    {cs_n, rd_n} <= 2'h0;
    @(posedge clk);
    idle();
    #1 d = rdata;
  endtask
endmodule // fhr_host_model

// ==== verification/tb.sv ====
// Purpose: Self-checking bench for the host register slice.
// Assumes: Erasures reach the read byte four erasure strobes late.
// Notes: Strobes are kept in separate cycles to avoid capture races.
`timescale 1ns/10ps
`include "fhr_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic clk, resetn, dbit, bstb, f0, f1, f2, r0, r1, r2, estb, cs_n, wr_n, rd_n, rate, mr;
  logic [4:0] addr;
  logic [7:0] wdata, rdata, nte, ete, rb, v;
  logic [23:0] per, eper;
  logic [3:0] pulse;
  logic [2:0] dq[$] = '{3'h0, 3'h0, 3'h0, 3'h0};
  logic [4:0] skip[6] = '{5'h0d, 5'h10, 5'h13, 5'h14, 5'h15, 5'h16};
  logic [4:0] ca[4] = '{5'h0e, 5'h0f, 5'h11, 5'h12};
  integer seed = 71775;
  int err_count = 0;
  int samples_checked = 0;
  fhr_host_model u_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n));
  fhr_host_regs u_dut (.clk(clk), .resetn(resetn), .bus_addr(addr), .bus_wdata(wdata), .bus_cs_n(cs_n),
    .bus_wr_n(wr_n), .bus_rd_n(rd_n), .bus_rdata(rdata), .decoded_bit_out(dbit), .bit_strobe(bstb),
    .first_stream_error_flag(f0), .second_stream_error_flag(f1), .third_stream_error_flag(f2),
    .first_stream_erasure_in(r0), .second_stream_erasure_in(r1), .third_stream_erasure_in(r2),
    .erasure_strobe(estb), .error_rate_period(per), .normalization_test_enable(nte),
    .error_rate_test_enable(ete), .rate_third(rate), .host_clock_pulse(pulse));
  task automatic report_and_stop();
    $display("checked=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One erasure shift, one bit capture, then a read of the output byte
  task automatic core_step();
    logic [2:0] d;
    v = 8'($random(seed));
    @(posedge clk);
    {r2, r1, r0} <= v[2:0];
    estb <= 1'b1;
    dq.push_front(v[2:0]);
    void'(dq.pop_back());
    d = dq[3];
    @(posedge clk);
    estb <= 1'b0;
    {dbit, f2, f1, f0} <= v[6:3];
    bstb <= 1'b1;
    @(posedge clk);
    bstb <= 1'b0;
    u_host.rd(`FHR_RD_DEC_OUT, rb);
    `CHK(rb, {2'b00, mr ? |d : d[0], 1'b0, mr ? v[5] : d[1], v[4], v[3], v[6]})
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    {resetn, dbit, bstb, f0, f1, f2, r0, r1, r2, estb} = 10'h0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1 `CHK({per, nte, ete, rate, pulse}, 45'h0)
    eper = 24'($random(seed));
    u_host.wr(`FHR_WR_PERIOD_LOW, eper[7:0]);
    u_host.wr(`FHR_WR_PERIOD_MID, eper[15:8]);
    u_host.wr(`FHR_WR_PERIOD_HIGH, eper[23:16]);
    for (int i = 0; i < 6; i++) begin
      v = (i < 4) ? 8'($random(seed)) : 8'h00;
      u_host.wr(skip[i], v);
      #1 `CHK(pulse, 4'h0)
    end
    `CHK({per, nte, ete, rate}, {eper, 17'h0})
    $display("test period and unused done");
    v = 8'($random(seed));
    u_host.wr(`FHR_WR_NORM_TEST, v);
    u_host.wr(`FHR_WR_ERR_TEST, ~v);
    #1 `CHK({nte, ete, per}, {v, ~v, eper})
    for (int i = 0; i < 4; i++) begin
      u_host.wr(ca[i], v);
      #1 `CHK(pulse, 4'h1 << i)
      @(posedge clk);
      #1 `CHK(pulse, 4'h0)
    end
    $display("test enables and clock pulses done");
    for (int r = 0; r < 2; r++) begin
      mr = r[0];
      u_host.wr(`FHR_WR_DEC_CTRL1, {3'b000, mr, 4'h0});
      #1 `CHK(rate, mr)
      repeat (12) core_step();
    end
    u_host.rd(`FHR_WR_PERIOD_LOW, rb);
    `CHK(rb, 8'h00)
    $display("test output byte done");
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1 `CHK({per, nte, ete, rate, pulse, rdata}, 53'h0)
    u_host.rd(`FHR_RD_DEC_OUT, rb);
    `CHK(rb, 8'h00)
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule // tb
